// [hdl/uimt_map.svh]
/*
  Register offsets, operand bit positions and timing figures of the user
  interrupt mask and timed start block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef UIMT_MAP_SVH
`define UIMT_MAP_SVH

// Register byte offsets (32-bit words, word aligned)
`define UIMT_OFS_ENABLE 8'h00
`define UIMT_OFS_DISABLE 8'h04
`define UIMT_OFS_FLUSH 8'h08
`define UIMT_OFS_TSTART 8'h0c
`define UIMT_OFS_MASK 8'h10
`define UIMT_OFS_PEND 8'h14
`define UIMT_OFS_TSTAT 8'h18
`define UIMT_OFS_ACTIVE 8'h1c

// Widths
`define UIMT_ADDR_W 8
`define UIMT_DATA_W 32
`define UIMT_OP_W 16
`define UIMT_PRIO_W 16

// Operand bit positions of the sources
`define UIMT_BIT_TIMED 0
`define UIMT_BIT_CNT1 1
`define UIMT_BIT_EV3 2
`define UIMT_BIT_EV2 3
`define UIMT_BIT_CNT0 4
`define UIMT_BIT_EV1 5
`define UIMT_BIT_EV0 6
`define UIMT_BIT_CNT5 7
`define UIMT_BIT_EV7 8
`define UIMT_BIT_CNT4 9
`define UIMT_BIT_EV6 10
`define UIMT_BIT_CNT3 11
`define UIMT_BIT_EV5 12
`define UIMT_BIT_CNT2 13
`define UIMT_BIT_EV4 14
`define UIMT_BIT_RSVD 15

// Bit of the running flag in the timer status word
`define UIMT_TSTAT_RUN_BIT 16

// Reset values
`define UIMT_MASK_RST 16'h0000
`define UIMT_ZERO_OP 16'h0000
`define UIMT_ZERO_PRIO 16'h0000
`define UIMT_ZERO_WORD 32'h0000_0000

// Timing: one millisecond tick from a 40 ns clock
`define UIMT_TICK_NS 1000000
`define UIMT_CLK_PERIOD_NS 40

`endif

// [hdl/uimt_pkg.sv]
/*
  Types of the user interrupt mask and timed start block.
  Assumes uimt_map.svh is on the include path.
*/
`default_nettype none
`include "uimt_map.svh"

package uimt_pkg;

  // One register bus request, all fields valid in the same cycle
  typedef struct packed {
    logic [`UIMT_ADDR_W-1:0] addr;
    logic [`UIMT_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } uimt_bus_req_type;

  // Timed generator state
  typedef struct packed {
    logic running;
    logic [`UIMT_OP_W-1:0] setpoint;
    logic [`UIMT_OP_W-1:0] acc;
  } uimt_timer_type;

endpackage : uimt_pkg

`default_nettype wire

// [hdl/uimt_sync.sv]
/*
  Three-stage pin synchroniser with agreement filter, one per bit.
  Assumes asynchronous pin inputs and one clock domain on the output side.
*/
`default_nettype none

module uimt_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // Block clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic [W-1:0] pin_i, // Raw pin levels
  output logic [W-1:0] level_o // Filtered level
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  if (W < 1)
  begin : g_w_chk
    $error("uimt_sync: W must be at least 1");
  end

  // First stage feeds only the second, guarding against metastability
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      level_o <= '0;
    else
      level_o <= (s2_r & s3_r) | (level_o & (s2_r | s3_r));
  end

endmodule : uimt_sync

`default_nettype wire

// [hdl/uimt_tick.sv]
/*
  Free running divider giving a one-cycle pulse every DIV clocks.
  Assumes a single clock; DIV shortens freely in simulation.
*/
`default_nettype none

module uimt_tick #(
  parameter int DIV = 25000
) (
  input wire logic clk_i, // Block clock
  input wire logic nrst_i, // Async reset, active low
  output logic tick_o // One-cycle pulse
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;

  if (DIV < 2)
  begin : g_div_chk
    $error("uimt_tick: DIV must be at least 2");
  end

  // Count up the period and pulse on wrap
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

endmodule : uimt_tick

`default_nettype wire

// [hdl/uimt_top.sv]
/*
  User interrupt mask, flush, priority dispatch and millisecond timed
  interrupt generator of a programmable controller.
  Assumes the scan engine drives rung and end-of-scan strobes on clk_i,
  event and counter sources arrive as asynchronous levels, and software
  reaches the registers over the plain strobe port.
*/
// Decided for this implementation: the strobed register port and the address map.
`default_nettype none
`include "uimt_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// R1: Disable instruction clears selected enable bits only
// R2: Enable instruction sets selected enable bits only
// R3: Event inputs map to bits 14,12,10,8,6,5,3,2
// R4: Counters map to bits 13,11,9,7,4,1
// R5: Timed interrupt is operand bit 0
// R6: Program keeps operand bit 15 zero
// R7: Program sums weights to select several sources
// R8: Timed setpoint is unsigned 16-bit milliseconds
// R9: Zero setpoint stops timer, clears running flag
// R10: Idle timer starts on nonzero setpoint, sets flag
// R11: New setpoint applies now, accumulated time kept
// R12: Setpoint below accumulated time times out immediately
// R13: Program may start the timer explicitly
// R14: Routine label always evaluates true
// R15: Flush discards selected pending requests
// R16: Program puts enabling output last on rung
// R17: Disabled source occurrence sets its pending bit
// R18: Service only at rung start or end-of-scan
// R19: Higher priority preempts, lower then completes
// R20: Fixed priority order, fault routine highest
// R21: Millisecond tick drives 16-bit accumulator compare
module uimt_top #(
  parameter int TICK_CYCLES = `UIMT_TICK_NS / `UIMT_CLK_PERIOD_NS
) (
  input wire logic clk_i, // Block clock, 25 MHz
  input wire logic nrst_i, // Async reset, active low
  input wire uimt_pkg::uimt_bus_req_type bus_req_i, // Register request
  output logic [`UIMT_DATA_W-1:0] rdata_o, // Read data, cycle after read
  input wire logic [7:0] event_input_irq_i, // Event input levels, async
  input wire logic [5:0] fast_counter_irq_i, // Counter interrupt levels, async
  input wire logic fault_i, // User fault pulse, same clock
  input wire logic rung_start_i, // Rung start strobe
  input wire logic end_of_scan_i, // End-of-scan phase level
  input wire logic svc_done_i, // Current routine finished pulse
  output logic svc_start_o, // Routine dispatch pulse
  output logic [`UIMT_PRIO_W-1:0] svc_sel_o, // Dispatched routine, one-hot by rank
  output logic [`UIMT_PRIO_W-1:0] exec_sel_o, // Executing routine, one-hot by rank
  output logic timed_running_flag_o, // Timed generator running
  output logic label_true_o // Routine label result
);
  localparam int OPW = `UIMT_OP_W;
  localparam int PW = `UIMT_PRIO_W;
  if (TICK_CYCLES < 2)
  begin : g_tick_chk
    $error("uimt_top: TICK_CYCLES must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Rank mapping: rank 0 is the fault routine, rank 15 the lowest source
  // Reorder operand bits into rank order, fault in rank 0
  function automatic logic [PW-1:0] to_rank(input logic [OPW-1:0] m, input logic f);
    to_rank = {m[`UIMT_BIT_CNT5], m[`UIMT_BIT_EV7], m[`UIMT_BIT_CNT4], m[`UIMT_BIT_EV6],
               m[`UIMT_BIT_CNT3], m[`UIMT_BIT_EV5], m[`UIMT_BIT_CNT2], m[`UIMT_BIT_EV4],
               m[`UIMT_BIT_TIMED], m[`UIMT_BIT_CNT1], m[`UIMT_BIT_EV3], m[`UIMT_BIT_EV2],
               m[`UIMT_BIT_CNT0], m[`UIMT_BIT_EV1], m[`UIMT_BIT_EV0], f}; // [R20]
  endfunction : to_rank

  // Map a rank vector back to operand bit order, dropping the fault
  function automatic logic [OPW-1:0] from_rank(input logic [PW-1:0] r);
    logic [OPW-1:0] m;
    m = `UIMT_ZERO_OP;
    {m[`UIMT_BIT_CNT5], m[`UIMT_BIT_EV7], m[`UIMT_BIT_CNT4], m[`UIMT_BIT_EV6],
     m[`UIMT_BIT_CNT3], m[`UIMT_BIT_EV5], m[`UIMT_BIT_CNT2], m[`UIMT_BIT_EV4],
     m[`UIMT_BIT_TIMED], m[`UIMT_BIT_CNT1], m[`UIMT_BIT_EV3], m[`UIMT_BIT_EV2],
     m[`UIMT_BIT_CNT0], m[`UIMT_BIT_EV1], m[`UIMT_BIT_EV0]} = r[PW-1:1];
    from_rank = m;
  endfunction : from_rank

  // Keep only the lowest set bit, which is the highest rank
  function automatic logic [PW-1:0] top_one(input logic [PW-1:0] v);
    top_one = v & (~v + 1'b1);
  endfunction : top_one

  //////////////////////////////////////////////////////////////////////////////
  // Source capture
  logic [7:0] ev_lvl;
  logic [5:0] cnt_lvl;
  logic [7:0] ev_lvl_r;
  logic [5:0] cnt_lvl_r;
  logic ms_tick;
  uimt_sync #(
    .W(8)
  ) u_ev_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(event_input_irq_i),
    .level_o(ev_lvl)
  );

  uimt_sync #(
    .W(6)
  ) u_cnt_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(fast_counter_irq_i),
    .level_o(cnt_lvl)
  );

  uimt_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_o(ms_tick)
  );

  // Previous filtered levels for rising edge detection
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ev_lvl_r <= '0;
      cnt_lvl_r <= '0;
    end
    else
    begin
      ev_lvl_r <= ev_lvl;
      cnt_lvl_r <= cnt_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register decode
  logic wr_en;
  logic wr_dis;
  logic wr_flush;
  logic wr_tstart;
  logic [OPW-1:0] wop;
  assign wop = bus_req_i.wdata[OPW-1:0];
  assign wr_en = bus_req_i.wr && (bus_req_i.addr == `UIMT_OFS_ENABLE);
  assign wr_dis = bus_req_i.wr && (bus_req_i.addr == `UIMT_OFS_DISABLE);
  assign wr_flush = bus_req_i.wr && (bus_req_i.addr == `UIMT_OFS_FLUSH);
  assign wr_tstart = bus_req_i.wr && (bus_req_i.addr == `UIMT_OFS_TSTART); // [R13]

  //////////////////////////////////////////////////////////////////////////////
  // Enable mask
  logic [OPW-1:0] en_mask_r;
  // Set and clear only the selected bits; bit 15 is never stored
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      en_mask_r <= `UIMT_MASK_RST;
    else if (wr_en)
      en_mask_r <= (en_mask_r | wop) & ~(OPW'(1) << `UIMT_BIT_RSVD); // [R2] [R6] [R7]
    else if (wr_dis)
      en_mask_r <= en_mask_r & ~wop; // [R1] [R7]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timed generator
  uimt_pkg::uimt_timer_type tmr_r;
  logic tmr_timeout;
  logic [OPW-1:0] acc_inc;
  assign acc_inc = tmr_r.acc + 1'b1;
  // Expiry on a tick, or at once when the new setpoint is already passed
  assign tmr_timeout = tmr_r.running &&
                       ((ms_tick && (acc_inc >= tmr_r.setpoint)) ||
                        (tmr_r.acc >= tmr_r.setpoint)); // [R21] [R12]

  // Setpoint writes win over expiry; expiry restarts the period
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tmr_r <= '0;
    else if (wr_tstart)
    begin
      tmr_r.setpoint <= wop; // [R8]
      if (wop == `UIMT_ZERO_OP)
      begin
        tmr_r.running <= 1'b0; // [R9]
        tmr_r.acc <= `UIMT_ZERO_OP;
      end
      else if (!tmr_r.running)
      begin
        tmr_r.running <= 1'b1; // [R10] [R13]
        tmr_r.acc <= `UIMT_ZERO_OP;
      end
      else if (ms_tick)
        tmr_r.acc <= acc_inc; // [R11]
    end
    else if (tmr_timeout)
      tmr_r.acc <= `UIMT_ZERO_OP;
    else if (tmr_r.running && ms_tick)
      tmr_r.acc <= acc_inc; // [R21]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending requests
  logic [OPW-1:0] occur;
  logic [OPW-1:0] pend_r;
  logic fault_pend_r;
  logic [OPW-1:0] grant_ops;
  logic grant;
  logic [PW-1:0] grant_sel;
  // Rising edges of every event and counter source, plus timer expiry, in operand order
  always_comb
  begin
    occur = `UIMT_ZERO_OP;
    occur[`UIMT_BIT_EV0] = ev_lvl[0] & ~ev_lvl_r[0]; // [R3]
    occur[`UIMT_BIT_EV1] = ev_lvl[1] & ~ev_lvl_r[1];
    occur[`UIMT_BIT_EV2] = ev_lvl[2] & ~ev_lvl_r[2];
    occur[`UIMT_BIT_EV3] = ev_lvl[3] & ~ev_lvl_r[3];
    occur[`UIMT_BIT_EV4] = ev_lvl[4] & ~ev_lvl_r[4];
    occur[`UIMT_BIT_EV5] = ev_lvl[5] & ~ev_lvl_r[5];
    occur[`UIMT_BIT_EV6] = ev_lvl[6] & ~ev_lvl_r[6];
    occur[`UIMT_BIT_EV7] = ev_lvl[7] & ~ev_lvl_r[7];
    occur[`UIMT_BIT_CNT0] = cnt_lvl[0] & ~cnt_lvl_r[0]; // [R4]
    occur[`UIMT_BIT_CNT1] = cnt_lvl[1] & ~cnt_lvl_r[1];
    occur[`UIMT_BIT_CNT2] = cnt_lvl[2] & ~cnt_lvl_r[2];
    occur[`UIMT_BIT_CNT3] = cnt_lvl[3] & ~cnt_lvl_r[3];
    occur[`UIMT_BIT_CNT4] = cnt_lvl[4] & ~cnt_lvl_r[4];
    occur[`UIMT_BIT_CNT5] = cnt_lvl[5] & ~cnt_lvl_r[5];
    occur[`UIMT_BIT_TIMED] = tmr_timeout; // [R5]
  end

  // Occurrences latch whatever the mask; a new occurrence beats flush or grant
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pend_r <= `UIMT_ZERO_OP;
    else
      pend_r <= (pend_r & ~(wr_flush ? wop : `UIMT_ZERO_OP) & ~grant_ops) | occur; // [R15] [R17]
  end

  // Fault requests are always enabled and cannot be flushed
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      fault_pend_r <= 1'b0;
    else
      fault_pend_r <= (fault_pend_r & ~(grant && grant_sel[0])) | fault_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dispatch and nesting
  logic [PW-1:0] active_r;
  logic [PW-1:0] cand;
  logic [PW-1:0] cur;
  logic [PW-1:0] cur_nxt;
  logic svc_point;
  assign svc_point = rung_start_i || end_of_scan_i; // [R18]
  assign cand = to_rank(pend_r & en_mask_r, fault_pend_r);
  assign cur = top_one(active_r);
  assign grant_sel = top_one(cand);
  // Smaller one-hot value means higher rank, so preemption is a compare
  assign grant = svc_point && (cand != `UIMT_ZERO_PRIO) &&
                 ((cur == `UIMT_ZERO_PRIO) || (grant_sel < cur)); // [R19] [R20]
  assign grant_ops = grant ? from_rank(grant_sel) : `UIMT_ZERO_OP;

  // Done retires the executing routine, revealing any suspended one
  always_comb
  begin
    cur_nxt = active_r;
    if (svc_done_i)
      cur_nxt = active_r & ~cur; // [R19]
    if (grant)
      cur_nxt = cur_nxt | grant_sel;
  end

  // Active set of started, unfinished routines
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      active_r <= `UIMT_ZERO_PRIO;
    else
      active_r <= cur_nxt;
  end

  // Dispatch outputs registered for clean timing
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      svc_start_o <= 1'b0;
      svc_sel_o <= `UIMT_ZERO_PRIO;
      exec_sel_o <= `UIMT_ZERO_PRIO;
    end
    else
    begin
      svc_start_o <= grant;
      svc_sel_o <= grant ? grant_sel : `UIMT_ZERO_PRIO;
      exec_sel_o <= top_one(cur_nxt);
    end
  end

  // Flag and label outputs
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      timed_running_flag_o <= 1'b0;
      label_true_o <= 1'b1;
    end
    else
    begin
      timed_running_flag_o <= (wr_tstart) ? (wop != `UIMT_ZERO_OP) : tmr_r.running; // [R9] [R10]
      label_true_o <= 1'b1; // [R14]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port
  // Read data stand only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= `UIMT_ZERO_WORD;
    else if (!bus_req_i.rd)
      rdata_o <= `UIMT_ZERO_WORD;
    else
    begin
      case (bus_req_i.addr)
        `UIMT_OFS_TSTART: rdata_o <= {{(`UIMT_DATA_W-OPW){1'b0}}, tmr_r.setpoint};
        `UIMT_OFS_MASK: rdata_o <= {{(`UIMT_DATA_W-OPW){1'b0}}, en_mask_r};
        `UIMT_OFS_PEND: rdata_o <= {{(`UIMT_DATA_W-OPW){1'b0}}, pend_r};
        // Running flag sits just above the accumulated count
        `UIMT_OFS_TSTAT: rdata_o <= {{(`UIMT_DATA_W-`UIMT_TSTAT_RUN_BIT-1){1'b0}}, tmr_r.running, tmr_r.acc};
        `UIMT_OFS_ACTIVE: rdata_o <= {{(`UIMT_DATA_W-PW){1'b0}}, active_r};
        default: rdata_o <= `UIMT_ZERO_WORD;
      endcase
    end
  end

endmodule : uimt_top

`default_nettype wire

// [tb/uimt_assertions.sv]
/*
  Concurrent checks of the user interrupt mask and timed start block.
  Assumes it is bound to uimt_top and sees only that module's ports.
*/
`default_nettype none
`include "uimt_map.svh"

////////////////////////////////////////////////////////////////////////////////
module uimt_assertions #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_i, // Block clock
  input wire logic nrst_i, // Async reset, active low
  input wire uimt_pkg::uimt_bus_req_type bus_req_i, // Register request
  input wire logic [`UIMT_DATA_W-1:0] rdata_o, // Read data
  input wire logic [7:0] event_input_irq_i, // Event levels
  input wire logic [5:0] fast_counter_irq_i, // Counter levels
  input wire logic fault_i, // Fault pulse
  input wire logic rung_start_i, // Rung start strobe
  input wire logic end_of_scan_i, // End-of-scan level
  input wire logic svc_done_i, // Routine finished
  input wire logic svc_start_o, // Dispatch pulse
  input wire logic [`UIMT_PRIO_W-1:0] svc_sel_o, // Dispatched rank
  input wire logic [`UIMT_PRIO_W-1:0] exec_sel_o, // Executing rank
  input wire logic timed_running_flag_o, // Timer running
  input wire logic label_true_o // Label result
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Setpoint write decode, shared by the timer checks
  logic tset_w;
  assign tset_w = bus_req_i.wr && (bus_req_i.addr == `UIMT_OFS_TSTART);

  ////////////////////////////////////////////////////////////////////////////////
  // Label stays true; timer flag follows setpoint writes only
  chk_label_true:
    assert property (label_true_o) else $error("label result not true");
  chk_stop_zero:
    assert property (tset_w && bus_req_i.wdata[15:0] == 16'h0000 |=> !timed_running_flag_o)
    else $error("zero setpoint left timer running");
  chk_start_nonzero:
    assert property (tset_w && bus_req_i.wdata[15:0] != 16'h0000 |=> timed_running_flag_o)
    else $error("nonzero setpoint did not start timer");
  chk_flag_rise:
    assert property ($rose(timed_running_flag_o) |-> $past(tset_w)) else $error("timer started without write");
  chk_flag_hold:
    assert property (timed_running_flag_o && !tset_w |=> timed_running_flag_o)
    else $error("running timer stopped by itself");

  ////////////////////////////////////////////////////////////////////////////////
  // Dispatch only at service points, one-hot, preemption only by a higher rank
  chk_svc_point:
    assert property (svc_start_o |-> $past(rung_start_i || end_of_scan_i)) else $error("dispatch off service point");
  chk_sel_onehot:
    assert property (svc_start_o ? $onehot(svc_sel_o) : (svc_sel_o == 16'h0000)) else $error("bad dispatch select");
  chk_exec_new:
    assert property (svc_start_o |-> exec_sel_o == svc_sel_o) else $error("dispatched routine not executing");
  chk_preempt_rank:
    assert property (svc_start_o && !$past(svc_done_i) && $past(exec_sel_o) != 16'h0000
      |-> svc_sel_o < $past(exec_sel_o)) else $error("lower rank preempted");
endmodule : uimt_assertions

bind uimt_top uimt_assertions #(.TICK_CYCLES(TICK_CYCLES)) uimt_assertions_i (.clk_i(clk_i), .nrst_i(nrst_i),
  .bus_req_i(bus_req_i), .rdata_o(rdata_o), .event_input_irq_i(event_input_irq_i),
  .fast_counter_irq_i(fast_counter_irq_i), .fault_i(fault_i), .rung_start_i(rung_start_i),
  .end_of_scan_i(end_of_scan_i), .svc_done_i(svc_done_i), .svc_start_o(svc_start_o), .svc_sel_o(svc_sel_o),
  .exec_sel_o(exec_sel_o), .timed_running_flag_o(timed_running_flag_o), .label_true_o(label_true_o));

`default_nettype wire

// [tb/tb.sv]
/*
  Self-checking bench of the user interrupt mask and timed start block.
  Assumes the design files and the checker are compiled before it.
*/
`default_nettype none
`include "uimt_map.svh"
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end

////////////////////////////////////////////////////////////////////////////////
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Long tick so an immediate time-out is told apart from a tick time-out
  localparam int TICK = 40;
  logic clk_i;
  logic nrst_i;
  uimt_pkg::uimt_bus_req_type bus_req_i;
  logic [`UIMT_DATA_W-1:0] rdata_o;
  logic [7:0] event_input_irq_i;
  logic [5:0] fast_counter_irq_i;
  logic fault_i;
  logic rung_start_i;
  logic end_of_scan_i;
  logic svc_done_i;
  logic svc_start_o;
  logic [`UIMT_PRIO_W-1:0] svc_sel_o;
  logic [`UIMT_PRIO_W-1:0] exec_sel_o;
  logic timed_running_flag_o;
  logic label_true_o;
  int miscompares;
  int tests_run;
  int cycles;
  int src_bit[14] = '{6, 5, 3, 2, 14, 12, 10, 8, 4, 1, 13, 11, 9, 7};

  uimt_top #(.TICK_CYCLES(TICK)) uimt_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .bus_req_i(bus_req_i),
    .rdata_o(rdata_o), .event_input_irq_i(event_input_irq_i), .fast_counter_irq_i(fast_counter_irq_i),
    .fault_i(fault_i), .rung_start_i(rung_start_i), .end_of_scan_i(end_of_scan_i), .svc_done_i(svc_done_i),
    .svc_start_o(svc_start_o), .svc_sel_o(svc_sel_o), .exec_sel_o(exec_sel_o),
    .timed_running_flag_o(timed_running_flag_o), .label_true_o(label_true_o));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      $display("Timeout after %0d cycles", cycles);
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus, service and source helpers
  task automatic bus(input logic [7:0] a, input logic [15:0] d, input logic w);
    @(posedge clk_i);
    bus_req_i <= '{addr: a, wdata: {16'h0000, d}, wr: w, rd: !w};
    @(posedge clk_i);
    bus_req_i <= '0;
  endtask : bus

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 16'h0000, 1'b0);
    #1;
    `CHECK(nm, e, rdata_o)
  endtask : rd_chk

  // One service point, then the dispatch it caused (zero means none)
  task automatic serve(input logic eos, input logic [15:0] e);
    @(posedge clk_i);
    rung_start_i <= !eos;
    end_of_scan_i <= eos;
    @(posedge clk_i);
    rung_start_i <= 1'b0;
    end_of_scan_i <= 1'b0;
    #1;
    `CHECK("svc_start", e != 16'h0000, svc_start_o)
    `CHECK("svc_sel", e, svc_sel_o)
  endtask : serve

  task automatic done(input logic [15:0] e);
    @(posedge clk_i);
    svc_done_i <= 1'b1;
    @(posedge clk_i);
    svc_done_i <= 1'b0;
    #1;
    `CHECK("exec_sel", e, exec_sel_o)
  endtask : done

  // Raise source n (events 0..7, counters 8..13) and let the filter settle
  task automatic occur(input int n);
    @(posedge clk_i);
    if (n < 8) event_input_irq_i[n] <= 1'b1;
    else fast_counter_irq_i[n-8] <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : occur

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {nrst_i, fault_i, rung_start_i, end_of_scan_i, svc_done_i} = '0;
    {bus_req_i, event_input_irq_i, fast_counter_irq_i} = '0;
    {miscompares, tests_run, cycles} = '0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk("mask", `UIMT_OFS_MASK, 32'h0000_0000);
    rd_chk("pend", `UIMT_OFS_PEND, 32'h0000_0000);
    rd_chk("tstat", `UIMT_OFS_TSTAT, 32'h0000_0000);
    `CHECK("label", 1'b1, label_true_o)
    $display("Test reset done");
    // Mask set and clear by summed weights; read-only place ignored, unmapped place reads zero
    bus(`UIMT_OFS_ENABLE, 16'h7fff, 1'b1);
    rd_chk("mask", `UIMT_OFS_MASK, 32'h0000_7fff);
    bus(`UIMT_OFS_DISABLE, 16'h0024, 1'b1);
    rd_chk("mask", `UIMT_OFS_MASK, 32'h0000_7fdb);
    bus(`UIMT_OFS_MASK, 16'hffff, 1'b1);
    rd_chk("mask", `UIMT_OFS_MASK, 32'h0000_7fdb);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    bus(`UIMT_OFS_DISABLE, 16'hffff, 1'b1);
    rd_chk("mask", `UIMT_OFS_MASK, 32'h0000_0000);
    $display("Test mask done");
    // Every event and counter source while masked: pending in its operand bit, then flushed
    foreach (src_bit[i])
    begin
      occur(i);
      rd_chk("src pend", `UIMT_OFS_PEND, 32'h1 << src_bit[i]);
      event_input_irq_i <= '0;
      fast_counter_irq_i <= '0;
      bus(`UIMT_OFS_FLUSH, 16'h0001 << src_bit[i], 1'b1);
      rd_chk("flush", `UIMT_OFS_PEND, 32'h0000_0000);
    end
    $display("Test mapping done");
    // Dispatch, preemption by rank, end-of-scan service, resumption
    bus(`UIMT_OFS_ENABLE, 16'h4040, 1'b1);
    occur(4);
    rd_chk("wait pend", `UIMT_OFS_PEND, 32'h0000_4000);
    serve(1'b0, 16'h0100);
    occur(0);
    serve(1'b0, 16'h0002);
    @(posedge clk_i);
    fault_i <= 1'b1;
    @(posedge clk_i);
    fault_i <= 1'b0;
    serve(1'b1, 16'h0001);
    rd_chk("active", `UIMT_OFS_ACTIVE, 32'h0000_0103);
    done(16'h0002);
    done(16'h0100);
    done(16'h0000);
    event_input_irq_i <= '0;
    $display("Test dispatch done");
    // Timer: start, expiry, shortened setpoint, timed dispatch, stop
    bus(`UIMT_OFS_TSTART, 16'h0003, 1'b1);
    rd_chk("setpoint", `UIMT_OFS_TSTART, 32'h0000_0003);
    `CHECK("run flag", 1'b1, timed_running_flag_o)
    bus(`UIMT_OFS_TSTAT, 16'h0000, 1'b0);
    #1;
    `CHECK("tstat run", 1'b1, rdata_o[`UIMT_TSTAT_RUN_BIT])
    repeat (3 * TICK + 10) @(posedge clk_i);
    rd_chk("timed pend", `UIMT_OFS_PEND, 32'h0000_0001);
    bus(`UIMT_OFS_TSTART, 16'h03e8, 1'b1);
    repeat (5 * TICK) @(posedge clk_i);
    bus(`UIMT_OFS_FLUSH, 16'h0001, 1'b1);
    bus(`UIMT_OFS_TSTART, 16'h0002, 1'b1);
    repeat (2) @(posedge clk_i);
    rd_chk("short pend", `UIMT_OFS_PEND, 32'h0000_0001);
    bus(`UIMT_OFS_ENABLE, 16'h0001, 1'b1);
    serve(1'b0, 16'h0080);
    done(16'h0000);
    bus(`UIMT_OFS_TSTART, 16'h0000, 1'b1);
    rd_chk("tstat", `UIMT_OFS_TSTAT, 32'h0000_0000);
    `CHECK("run flag", 1'b0, timed_running_flag_o)
    $display("Test timer done");
    finish_test();
  end
endmodule : tb

`default_nettype wire
